/* common/dsi_pkg.sv */
// package: register map, fields and reset values of the dpll status block
package dsi_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  localparam logic [8:0] OFS_IRQ_EN_STATE = 9'h05b;
  localparam logic [8:0] OFS_IRQ_EN_LIMIT = 9'h05c;
  localparam logic [8:0] OFS_OFFSET_READBACK_A_B0      = 9'h065;
  localparam logic [8:0] OFS_OFFSET_READBACK_A_B1      = 9'h066;
  localparam logic [8:0] OFS_OFFSET_READBACK_A_B2      = 9'h067;
  localparam logic [8:0] OFS_OFFSET_READBACK_A_B3      = 9'h068;
  localparam logic [8:0] OFS_PHASE_B0     = 9'h07d;
  localparam logic [8:0] OFS_PHASE_B1     = 9'h07e;
  localparam logic [8:0] OFS_PHASE_B2     = 9'h07f;
  localparam logic [8:0] OFS_PHASE_B3     = 9'h080;
  localparam logic [8:0] OFS_FLAGS_STATE  = 9'h059;
  localparam logic [8:0] OFS_FLAGS_LIMIT  = 9'h05a;
  localparam logic [8:0] OFS_NOMINAL_B0   = 9'h090;

  localparam int NOMINAL_W      = 40;
  localparam int NOMINAL_BYTES  = 5;

  localparam int BIT_LOCK_LOSS  = 5;
  localparam int BIT_TRACKING   = 4;
  localparam int BIT_HOLDOVER   = 3;
  localparam int BIT_OFFSET_READBACK_A_LIMIT = 2;

  localparam logic [7:0] MASK_STATE = 8'h38;
  localparam logic [7:0] MASK_LIMIT = 8'h04;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [39:0] RST_NOMINAL = 40'h00_0000_0000;
endpackage

/* verilog/dsi_status_regs.sv */
// module: dpll status enables, latched flags, irq status and readbacks
`timescale 1ns/1ps

// Function
// - lock-loss enable bit 5 lets its latched flag raise pll irq status
// - tracking enable bit 4 lets its latched flag raise pll irq status
// - holdover enable bit 3 lets its latched flag raise pll irq status
// - offset_readback_a-limit enable bit 2 lets its latched flag raise irq status
// - frequency readback is 32 bits over four bytes, low address first
// - frequency readback is read-only signed offset to nominal word
// - nominal tuning word is a 40-bit value in its own registers
// - phase readback is 32 bits over four bytes, low address first
// - phase readback is signed present phase-detector output
// - one phase readback step is two to minus ten nanoseconds
// - positive phase means input leads feedback clock
// - lock-loss latched flag sets on any change of lock-loss status
// - offset_readback_a-limit latched flag sets on any change of its status
// - latched flags clear on write of one; zero leaves them
module dsi_status_regs (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [8:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  input  wire logic              lock_loss_status,
  input  wire logic              tracking_status,
  input  wire logic              holdover_status,
  input  wire logic              offset_readback_a_limit_status,
  input  wire logic [31:0]       offset_readback_a,
  input  wire logic [31:0]       phase_detector,
  output logic                   pll_irq_status,
  output logic      [39:0]       nominal_tuning_word
);

  // ----------------------------------------------------------------
  // status input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_r;
  logic [3:0] sync1_nxt;
  logic [3:0] sync2_r;
  logic [3:0] sync2_nxt;
  logic [3:0] prev_r;
  logic [3:0] prev_nxt;
  logic       prime_r;
  logic       prime_nxt;

  always_comb begin
    sync1_nxt = {lock_loss_status, tracking_status,
                 holdover_status, offset_readback_a_limit_status};
    sync2_nxt = sync1_r;
    prev_nxt  = sync2_r;
    prime_nxt = 1'b1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      prev_r  <= 4'h0;
      prime_r <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r  <= prev_nxt;
      prime_r <= prime_nxt;
    end
  end

  // change of any status in either direction
  logic [3:0] change;
  assign change = prime_r ? (sync2_r ^ prev_r) : 4'h0;

  // ----------------------------------------------------------------
  // enables, latched flags, nominal word
  // ----------------------------------------------------------------
  logic [7:0]  en_state_r;
  logic [7:0]  en_state_nxt;
  logic [7:0]  en_limit_r;
  logic [7:0]  en_limit_nxt;
  logic [7:0]  flg_state_r;
  logic [7:0]  flg_state_nxt;
  logic [7:0]  flg_limit_r;
  logic [7:0]  flg_limit_nxt;
  logic [39:0] nom_r;
  logic [39:0] nom_nxt;
  logic        irq_r;
  logic        irq_nxt;

  function automatic logic hit(input logic [8:0] a, input logic [8:0] o);
    hit = (a == o);
  endfunction

  always_comb begin
    en_state_nxt  = en_state_r;
    en_limit_nxt  = en_limit_r;
    flg_state_nxt = flg_state_r;
    flg_limit_nxt = flg_limit_r;
    nom_nxt       = nom_r;
    if (reg_wr) begin
      if (hit(reg_addr, dsi_pkg::OFS_IRQ_EN_STATE)) begin
        en_state_nxt = reg_wdata & dsi_pkg::MASK_STATE;
      end
      if (hit(reg_addr, dsi_pkg::OFS_IRQ_EN_LIMIT)) begin
        en_limit_nxt = reg_wdata & dsi_pkg::MASK_LIMIT;
      end
      if (hit(reg_addr, dsi_pkg::OFS_FLAGS_STATE)) begin
        flg_state_nxt = flg_state_r & ~reg_wdata;
      end
      if (hit(reg_addr, dsi_pkg::OFS_FLAGS_LIMIT)) begin
        flg_limit_nxt = flg_limit_r & ~reg_wdata;
      end
      for (int i = 0; i < dsi_pkg::NOMINAL_BYTES; i++) begin
        if (reg_addr == dsi_pkg::OFS_NOMINAL_B0 + 9'(i)) begin
          nom_nxt[i*8 +: 8] = reg_wdata;
        end
      end
    end
    // set wins over a clear in the same cycle
    if (change[3]) begin
      flg_state_nxt[dsi_pkg::BIT_LOCK_LOSS] = 1'b1;
    end
    if (change[2]) begin
      flg_state_nxt[dsi_pkg::BIT_TRACKING] = 1'b1;
    end
    if (change[1]) begin
      flg_state_nxt[dsi_pkg::BIT_HOLDOVER] = 1'b1;
    end
    if (change[0]) begin
      flg_limit_nxt[dsi_pkg::BIT_OFFSET_READBACK_A_LIMIT] = 1'b1;
    end
    irq_nxt = |(flg_state_nxt & en_state_nxt & dsi_pkg::MASK_STATE)
              | |(flg_limit_nxt & en_limit_nxt & dsi_pkg::MASK_LIMIT);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_state_r  <= dsi_pkg::RST_BYTE;
      en_limit_r  <= dsi_pkg::RST_BYTE;
      flg_state_r <= dsi_pkg::RST_BYTE;
      flg_limit_r <= dsi_pkg::RST_BYTE;
      nom_r       <= dsi_pkg::RST_NOMINAL;
      irq_r       <= 1'b0;
    end else begin
      en_state_r  <= en_state_nxt;
      en_limit_r  <= en_limit_nxt;
      flg_state_r <= flg_state_nxt;
      flg_limit_r <= flg_limit_nxt;
      nom_r       <= nom_nxt;
      irq_r       <= irq_nxt;
    end
  end

  assign pll_irq_status      = irq_r;
  assign nominal_tuning_word = nom_r;

  // ----------------------------------------------------------------
  // readback snapshots and read data
  // ----------------------------------------------------------------
  logic [31:0] frq_snap_r;
  logic [31:0] frq_snap_nxt;
  logic [31:0] phs_snap_r;
  logic [31:0] phs_snap_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;

  always_comb begin
    frq_snap_nxt = frq_snap_r;
    phs_snap_nxt = phs_snap_r;
    rdata_nxt    = rdata_r;
    if (reg_rd) begin
      if (hit(reg_addr, dsi_pkg::OFS_OFFSET_READBACK_A_B0)) begin
        frq_snap_nxt = offset_readback_a;
      end
      if (hit(reg_addr, dsi_pkg::OFS_PHASE_B0)) begin
        phs_snap_nxt = phase_detector;
      end
      rdata_nxt = dsi_pkg::RST_BYTE;
      case (reg_addr)
        dsi_pkg::OFS_IRQ_EN_STATE: rdata_nxt = en_state_r;
        dsi_pkg::OFS_IRQ_EN_LIMIT: rdata_nxt = en_limit_r;
        dsi_pkg::OFS_FLAGS_STATE:  rdata_nxt = flg_state_r;
        dsi_pkg::OFS_FLAGS_LIMIT:  rdata_nxt = flg_limit_r;
        dsi_pkg::OFS_OFFSET_READBACK_A_B0:      rdata_nxt = offset_readback_a[7:0];
        dsi_pkg::OFS_OFFSET_READBACK_A_B1:      rdata_nxt = frq_snap_r[15:8];
        dsi_pkg::OFS_OFFSET_READBACK_A_B2:      rdata_nxt = frq_snap_r[23:16];
        dsi_pkg::OFS_OFFSET_READBACK_A_B3:      rdata_nxt = frq_snap_r[31:24];
        dsi_pkg::OFS_PHASE_B0:     rdata_nxt = phase_detector[7:0];
        dsi_pkg::OFS_PHASE_B1:     rdata_nxt = phs_snap_r[15:8];
        dsi_pkg::OFS_PHASE_B2:     rdata_nxt = phs_snap_r[23:16];
        dsi_pkg::OFS_PHASE_B3:     rdata_nxt = phs_snap_r[31:24];
        default: begin
          for (int i = 0; i < dsi_pkg::NOMINAL_BYTES; i++) begin
            if (reg_addr == dsi_pkg::OFS_NOMINAL_B0 + 9'(i)) begin
              rdata_nxt = nom_r[i*8 +: 8];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frq_snap_r <= dsi_pkg::RST_WORD;
      phs_snap_r <= dsi_pkg::RST_WORD;
      rdata_r    <= dsi_pkg::RST_BYTE;
    end else begin
      frq_snap_r <= frq_snap_nxt;
      phs_snap_r <= phs_snap_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

endmodule

/* verification/dsi_status_regs_checker.sv */
// checker: port properties of the dpll status block
`timescale 1ns/1ps
module dsi_status_regs_checker (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [8:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [31:0] offset_readback_a,
  input wire logic [31:0] phase_detector,
  input wire logic [39:0] nominal_tuning_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rd_at(logic [8:0] a); reg_rd && reg_addr == a; endsequence
  sequence wr_at(logic [8:0] a); reg_wr && reg_addr == a; endsequence
  hold_rdata_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (reg_rd && reg_addr[8] |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  offset_readback_a_low_a: assert property (rd_at(dsi_pkg::OFS_OFFSET_READBACK_A_B0) |=>
    reg_rdata == $past(offset_readback_a[7:0])) else $error("offset_readback_a low");
  phase_low_a: assert property (rd_at(dsi_pkg::OFS_PHASE_B0) |=>
    reg_rdata == $past(phase_detector[7:0])) else $error("phase low");
  offset_readback_a_snap_a: assert property (rd_at(dsi_pkg::OFS_OFFSET_READBACK_A_B0) ##1
    rd_at(dsi_pkg::OFS_OFFSET_READBACK_A_B1) |=>
    reg_rdata == $past(offset_readback_a[15:8], 2)) else $error("offset_readback_a snap");
  phase_snap_a: assert property (rd_at(dsi_pkg::OFS_PHASE_B0) ##1
    rd_at(dsi_pkg::OFS_PHASE_B1) |=>
    reg_rdata == $past(phase_detector[15:8], 2)) else $error("phase snap");
  en_state_a: assert property (wr_at(dsi_pkg::OFS_IRQ_EN_STATE) ##1
    rd_at(dsi_pkg::OFS_IRQ_EN_STATE) |=> reg_rdata ==
    ($past(reg_wdata, 2) & dsi_pkg::MASK_STATE))
    else $error("state enable readback");
  en_limit_a: assert property (wr_at(dsi_pkg::OFS_IRQ_EN_LIMIT) ##1
    rd_at(dsi_pkg::OFS_IRQ_EN_LIMIT) |=> reg_rdata ==
    ($past(reg_wdata, 2) & dsi_pkg::MASK_LIMIT))
    else $error("limit enable readback");
  nominal_wr_a: assert property (wr_at(dsi_pkg::OFS_NOMINAL_B0) |=>
    nominal_tuning_word[7:0] == $past(reg_wdata)) else $error("nominal");
endmodule
bind dsi_status_regs dsi_status_regs_checker dsi_status_regs_checker_i (
  .clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .offset_readback_a, .phase_detector, .nominal_tuning_word);

/* verification/dsi_status_regs_tb_top.sv */
// testbench: register, flag and readback scenarios for the status block
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", n, e, s); n_mismatch++; end end
module dsi_status_regs_tb_top;
  logic        clk, rstn, reg_wr, reg_rd, irq;
  logic        pend = 1'b0;
  logic [8:0]  reg_addr, base, fa;
  logic [7:0]  reg_wdata, reg_rdata, m, e_v;
  logic [3:0]  st;
  logic [31:0] frq, phs, rnd, held;
  logic [39:0] ntw, ntw_e;
  logic [7:0]  exp_q[$];
  logic [8:0]  al[5] = '{9'h05b, 9'h05c, 9'h068, 9'h080, 9'h1ff};
  int          n_mismatch, n_checks;
  dsi_status_regs dsi_status_regs_i (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .lock_loss_status(st[0]), .tracking_status(st[1]),
    .holdover_status(st[2]), .offset_readback_a_limit_status(st[3]),
    .offset_readback_a(frq), .phase_detector(phs),
    .pll_irq_status(irq), .nominal_tuning_word(ntw));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic op(logic w, logic r, logic [8:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic rd(logic [8:0] a, logic [7:0] e);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pend) begin
      e_v = exp_q.pop_front();
      `CHK("rdata", e_v, reg_rdata)
    end
    pend <= reg_rd;
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    {rstn, reg_wr, reg_rd, st} = '0;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    frq = 32'h0000_0000;
    phs = 32'h0000_0000;
    rnd = 32'h0000_004d;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    foreach (al[k]) rd(al[k], 8'h00);
    for (int f = 0; f < 2; f++) begin
      rnd = lfsr(rnd);
      held = f ? ~rnd : rnd;
      frq <= rnd;
      phs <= ~rnd;
      base = f ? 9'h07d : 9'h065;
      op(1'b1, 1'b0, base + 9'h003, 8'hff);
      for (int k = 0; k < 4; k++) begin
        rd(base + k[8:0], held[8*k +: 8]);
        if (k == 1) begin
          frq <= lfsr(rnd);
          phs <= rnd;
        end
      end
    end
    for (int i = 0; i < 4; i++) begin
      m = 8'h20 >> i;
      fa = (i < 3) ? 9'h059 : 9'h05a;
      op(1'b1, 1'b0, fa + 9'h002, 8'h00);
      st[i] <= ~st[i];
      repeat (6) op(1'b0, 1'b0, 9'h000, 8'h00);
      #1 `CHK("irq off", 1'b0, irq)
      op(1'b1, 1'b0, fa + 9'h002, 8'hff);
      rd(fa + 9'h002, (i < 3) ? 8'h38 : 8'h04);
      op(1'b1, 1'b0, fa, 8'h00);
      rd(fa, m);
      #1 `CHK("irq on", 1'b1, irq)
      op(1'b1, 1'b0, fa, m);
      rd(fa, 8'h00);
      repeat (2) op(1'b0, 1'b0, 9'h000, 8'h00);
      #1 `CHK("irq clear", 1'b0, irq)
    end
    for (int b = 0; b < 5; b++) begin
      rnd = lfsr(rnd);
      ntw_e[8*b +: 8] = rnd[7:0];
      op(1'b1, 1'b0, 9'h090 + b[8:0], rnd[7:0]);
    end
    repeat (3) op(1'b0, 1'b0, 9'h000, 8'h00);
    #1 `CHK("nominal", ntw_e, ntw)
    end_sim();
  end
endmodule
